// [rtl/gpio_cmd_if.sv]
// Command, response and event link between host controller and GPIO device
`timescale 1ns/1ps
`default_nettype none
interface gpio_cmd_if;
  logic       cmd_valid;
  logic [7:0] cmd_type;
  logic [7:0] cmd_len;
  logic [7:0] cmd_group;
  logic [7:0] cmd_id;
  logic [7:0] cmd_port;
  logic [7:0] cmd_mask;
  logic [7:0] cmd_a;
  logic [7:0] cmd_b;
  logic [7:0] cmd_c;
  logic [7:0] cmd_d;
  logic       rsp_valid;
  logic [7:0] rsp_id;
  logic [7:0] rsp_len;
  logic [7:0] rsp_d0;
  logic [7:0] rsp_d1;
  logic [7:0] rsp_d2;
  logic [7:0] rsp_d3;
  logic       evt_valid;
  logic [7:0] evt_port;
  logic [7:0] evt_logic;

  modport dev (
    input  cmd_valid, cmd_type, cmd_len, cmd_group, cmd_id, cmd_port,
    input  cmd_mask, cmd_a, cmd_b, cmd_c, cmd_d,
    output rsp_valid, rsp_id, rsp_len, rsp_d0, rsp_d1, rsp_d2, rsp_d3,
    output evt_valid, evt_port, evt_logic
  );
  modport host (
    output cmd_valid, cmd_type, cmd_len, cmd_group, cmd_id, cmd_port,
    output cmd_mask, cmd_a, cmd_b, cmd_c, cmd_d,
    input  rsp_valid, rsp_id, rsp_len, rsp_d0, rsp_d1, rsp_d2, rsp_d3,
    input  evt_valid, evt_port, evt_logic
  );
endinterface : gpio_cmd_if
`default_nettype wire

// [rtl/gpio_cmd_pkg.sv]
// Shared constants for the GPIO command link and its host controller
package gpio_cmd_pkg;
  localparam int          PIN_W        = 8;
  localparam int          MAX_PORTS    = 6;
  localparam logic [7:0]  HDR_TYPE     = 8'hc0;
  localparam logic [7:0]  GPIO_GROUP   = 8'h09;
  // Command identifiers inside the GPIO group
  localparam logic [7:0]  ID_EDGE_EVT  = 8'h01;
  localparam logic [7:0]  ID_SET_DRIVE = 8'h05;
  localparam logic [7:0]  ID_GET_DRIVE = 8'h06;
  localparam logic [7:0]  ID_SET_LEVEL = 8'h07;
  localparam logic [7:0]  ID_GET_LEVEL = 8'h08;
  localparam logic [7:0]  ID_SET_IRQ   = 8'h09;
  localparam logic [7:0]  ID_GET_IRQ   = 8'h0a;
  // Command lengths
  localparam logic [7:0]  CLEN_SET_DRV = 8'h06;
  localparam logic [7:0]  CLEN_SET_LVL = 8'h03;
  localparam logic [7:0]  CLEN_SET_IRQ = 8'h04;
  localparam logic [7:0]  CLEN_GET     = 8'h01;
  // Response lengths
  localparam logic [7:0]  RLEN_SET     = 8'h03;
  localparam logic [7:0]  RLEN_GET_DRV = 8'h06;
  localparam logic [7:0]  RLEN_GET_LVL = 8'h03;
  localparam logic [7:0]  RLEN_GET_IRQ = 8'h04;
  localparam logic [7:0]  RLEN_NONE    = 8'h00;
  // Host controller register byte addresses
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_ARGS     = 8'h04;
  localparam logic [7:0]  REG_ARGD     = 8'h08;
  localparam logic [7:0]  REG_RSP_DATA = 8'h0c;
  localparam logic [7:0]  REG_RSP_INFO = 8'h10;
  localparam logic [7:0]  REG_STATUS   = 8'h14;
  localparam logic [7:0]  REG_MASK     = 8'h18;
  localparam logic [7:0]  REG_EVT      = 8'h1c;
  // Status bit positions
  localparam int          ST_RSP       = 0;
  localparam int          ST_EVT       = 1;
  localparam int          ST_W         = 2;
  // Reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
endpackage : gpio_cmd_pkg

// [rtl/gpio_dev_end.sv]
// GPIO device end: drive mode, output level and edge interrupt state
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Only masked pins of port 0-5 change
// - Direction bit one means output, zero input
// - Low-side bit enables pull-down or drive-low
// - High-side bit enables pull-up or drive-high
// - Analog bit forces hi-Z analog input
// - Four mode bits decode to fixed drive table
// - Set commands answer mask of changed pins
// - Drive readback returns four masks, length 06
// - Set-level writes output data, pins may differ
// - Set-level writes selected pins high or low
// - Level readback returns written, not live, levels
// - Edge command sets rising and falling enables
// - Selected pins enable edges per bit
// - Special-function pins interrupt regardless of enables
// - Edge event carries port levels at detection
module gpio_dev_end #(
  parameter int NUM_PORTS = 6
) (
  input  wire logic                              mclk_i,
  input  wire logic                              sys_rst_i,
  gpio_cmd_if.dev                                lnk,
  input  wire logic [NUM_PORTS-1:0][7:0]         pin_lvl_i,
  input  wire logic [NUM_PORTS-1:0][7:0]         special_fn_i,
  output logic      [NUM_PORTS-1:0][7:0]         pin_out_o,
  output logic      [NUM_PORTS-1:0][7:0]         pin_oe_n_o,
  output logic      [NUM_PORTS-1:0][7:0]         pull_up_o,
  output logic      [NUM_PORTS-1:0][7:0]         pull_dn_o,
  output logic      [NUM_PORTS-1:0][7:0]         analog_o,
  output logic                                   fn_irq_o
);
  typedef logic [NUM_PORTS-1:0][7:0] port_arr_t;
  if (NUM_PORTS < 1 || NUM_PORTS > gpio_cmd_pkg::MAX_PORTS) begin : g_chk
    $error("NUM_PORTS must lie in 1..6");
  end
  // Replace selected bits of a mask, keep the others
  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] sel,
                                       input logic [7:0] new_v);
    merge = (old_v & ~sel) | (new_v & sel);
  endfunction : merge

  port_arr_t  dir_q, dir_d, dn_q, dn_d, up_q, up_d, ana_q, ana_d;
  port_arr_t  lvl_q, lvl_d, rise_q, rise_d, fall_q, fall_d;
  logic       rsp_valid_q, rsp_valid_d;
  logic [7:0] rsp_id_q, rsp_id_d, rsp_len_q, rsp_len_d;
  logic [7:0] rsp_d0_q, rsp_d0_d, rsp_d1_q, rsp_d1_d;
  logic [7:0] rsp_d2_q, rsp_d2_d, rsp_d3_q, rsp_d3_d;
  logic [2:0] p;
  logic       port_ok;
  logic [7:0] m;

  assign p       = lnk.cmd_port[2:0];
  assign m       = lnk.cmd_mask;
  assign port_ok = (lnk.cmd_port < 8'(NUM_PORTS))
                   && (lnk.cmd_type == gpio_cmd_pkg::HDR_TYPE)
                   && (lnk.cmd_group == gpio_cmd_pkg::GPIO_GROUP);

  // Command decode: next configuration and the one-cycle answer
  always_comb begin
    dir_d       = dir_q;
    dn_d        = dn_q;
    up_d        = up_q;
    ana_d       = ana_q;
    lvl_d       = lvl_q;
    rise_d      = rise_q;
    fall_d      = fall_q;
    rsp_valid_d = lnk.cmd_valid;
    rsp_id_d    = lnk.cmd_id;
    rsp_len_d   = gpio_cmd_pkg::RLEN_NONE;
    rsp_d0_d    = gpio_cmd_pkg::RST_BYTE;
    rsp_d1_d    = gpio_cmd_pkg::RST_BYTE;
    rsp_d2_d    = gpio_cmd_pkg::RST_BYTE;
    rsp_d3_d    = gpio_cmd_pkg::RST_BYTE;
    if (lnk.cmd_valid && port_ok) begin
      case (lnk.cmd_id)
        gpio_cmd_pkg::ID_SET_DRIVE: begin
          dir_d[p]  = merge(dir_q[p], m, lnk.cmd_a);
          dn_d[p]   = merge(dn_q[p], m, lnk.cmd_b);
          up_d[p]   = merge(up_q[p], m, lnk.cmd_c);
          ana_d[p]  = merge(ana_q[p], m, lnk.cmd_d);
          rsp_len_d = gpio_cmd_pkg::RLEN_SET;
          rsp_d0_d  = m & ((dir_q[p] ^ lnk.cmd_a) | (dn_q[p] ^ lnk.cmd_b)
                    | (up_q[p] ^ lnk.cmd_c) | (ana_q[p] ^ lnk.cmd_d));
        end
        gpio_cmd_pkg::ID_GET_DRIVE: begin
          rsp_len_d = gpio_cmd_pkg::RLEN_GET_DRV;
          rsp_d0_d  = dir_q[p];
          rsp_d1_d  = dn_q[p];
          rsp_d2_d  = up_q[p];
          rsp_d3_d  = ana_q[p];
        end
        gpio_cmd_pkg::ID_SET_LEVEL: begin
          lvl_d[p]  = merge(lvl_q[p], m, lnk.cmd_a);
          rsp_len_d = gpio_cmd_pkg::RLEN_SET;
          rsp_d0_d  = m & (lvl_q[p] ^ lnk.cmd_a);
        end
        gpio_cmd_pkg::ID_GET_LEVEL: begin
          rsp_len_d = gpio_cmd_pkg::RLEN_GET_LVL;
          rsp_d0_d  = lvl_q[p];
        end
        gpio_cmd_pkg::ID_SET_IRQ: begin
          rise_d[p] = merge(rise_q[p], m, lnk.cmd_a);
          fall_d[p] = merge(fall_q[p], m, lnk.cmd_b);
          rsp_len_d = gpio_cmd_pkg::RLEN_SET;
          rsp_d0_d  = m & ((rise_q[p] ^ lnk.cmd_a)
                    | (fall_q[p] ^ lnk.cmd_b));
        end
        gpio_cmd_pkg::ID_GET_IRQ: begin
          rsp_len_d = gpio_cmd_pkg::RLEN_GET_IRQ;
          rsp_d0_d  = rise_q[p];
          rsp_d1_d  = fall_q[p];
        end
        default: rsp_len_d = gpio_cmd_pkg::RLEN_NONE;
      endcase
    end
  end

  // Configuration state and answer registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      dir_q       <= '0;
      dn_q        <= '0;
      up_q        <= '0;
      ana_q       <= '0;
      lvl_q       <= '0;
      rise_q      <= '0;
      fall_q      <= '0;
      rsp_valid_q <= 1'b0;
      rsp_id_q    <= gpio_cmd_pkg::RST_BYTE;
      rsp_len_q   <= gpio_cmd_pkg::RST_BYTE;
      rsp_d0_q    <= gpio_cmd_pkg::RST_BYTE;
      rsp_d1_q    <= gpio_cmd_pkg::RST_BYTE;
      rsp_d2_q    <= gpio_cmd_pkg::RST_BYTE;
      rsp_d3_q    <= gpio_cmd_pkg::RST_BYTE;
    end else begin
      dir_q       <= dir_d;
      dn_q        <= dn_d;
      up_q        <= up_d;
      ana_q       <= ana_d;
      lvl_q       <= lvl_d;
      rise_q      <= rise_d;
      fall_q      <= fall_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_id_q    <= rsp_id_d;
      rsp_len_q   <= rsp_len_d;
      rsp_d0_q    <= rsp_d0_d;
      rsp_d1_q    <= rsp_d1_d;
      rsp_d2_q    <= rsp_d2_d;
      rsp_d3_q    <= rsp_d3_d;
    end
  end
  // Answer fields toward the host end
  assign lnk.rsp_valid = rsp_valid_q;
  assign lnk.rsp_id    = rsp_id_q;
  assign lnk.rsp_len   = rsp_len_q;
  assign lnk.rsp_d0    = rsp_d0_q;
  assign lnk.rsp_d1    = rsp_d1_q;
  assign lnk.rsp_d2    = rsp_d2_q;
  assign lnk.rsp_d3    = rsp_d3_q;
  // Pad driver decode from the four mode bits
  port_arr_t out_d, oe_n_d, pu_d, pd_d;
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      for (int b = 0; b < gpio_cmd_pkg::PIN_W; b++) begin
        out_d[i][b]  = lvl_q[i][b];
        oe_n_d[i][b] = 1'b1;
        pu_d[i][b]   = 1'b0;
        pd_d[i][b]   = 1'b0;
        if (ana_q[i][b]) begin
          oe_n_d[i][b] = 1'b1;
        end else if (!dir_q[i][b]) begin
          pu_d[i][b]   = up_q[i][b];
          pd_d[i][b]   = dn_q[i][b];
        end else if (up_q[i][b] && !dn_q[i][b]) begin
          oe_n_d[i][b] = ~lvl_q[i][b];
        end else if (dn_q[i][b] && !up_q[i][b]) begin
          oe_n_d[i][b] = lvl_q[i][b];
        end else begin
          oe_n_d[i][b] = 1'b0;
        end
      end
    end
  end

  // Pad driver registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pin_out_o  <= '0;
      pin_oe_n_o <= '1;
      pull_up_o  <= '0;
      pull_dn_o  <= '0;
      analog_o   <= '0;
    end else begin
      pin_out_o  <= out_d;
      pin_oe_n_o <= oe_n_d;
      pull_up_o  <= pu_d;
      pull_dn_o  <= pd_d;
      analog_o   <= ana_q;
    end
  end
  // Edge detection, per-port pending events and captured levels
  port_arr_t                prev_q, cap_q, cap_d;
  logic [NUM_PORTS-1:0]     pend_q, pend_d, hit;
  logic                     primed_q;
  logic                     evt_valid_q, evt_valid_d, fn_irq_d;
  logic [7:0]               evt_port_q, evt_port_d, evt_logic_q, evt_logic_d;
  logic                     found;
  // Edge compare, lowest-port event pick and level capture
  always_comb begin
    pend_d      = pend_q;
    cap_d       = cap_q;
    fn_irq_d    = 1'b0;
    evt_valid_d = 1'b0;
    evt_port_d  = evt_port_q;
    evt_logic_d = evt_logic_q;
    found       = 1'b0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      hit[i] = primed_q
        && |((pin_lvl_i[i] & ~prev_q[i] & rise_q[i])
           | (~pin_lvl_i[i] & prev_q[i] & fall_q[i]));
      if (primed_q && |((pin_lvl_i[i] ^ prev_q[i]) & special_fn_i[i])) begin
        fn_irq_d = 1'b1;
      end
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (pend_q[i] && !found) begin
        found       = 1'b1;
        evt_valid_d = 1'b1;
        evt_port_d  = 8'(i);
        evt_logic_d = cap_q[i];
        pend_d[i]   = 1'b0;
      end
    end
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (hit[i]) begin
        pend_d[i] = 1'b1;                                // set beats clear
        cap_d[i]  = pin_lvl_i[i];
      end
    end
  end

  // Edge and event registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      prev_q      <= '0;
      cap_q       <= '0;
      pend_q      <= '0;
      primed_q    <= 1'b0;
      evt_valid_q <= 1'b0;
      evt_port_q  <= gpio_cmd_pkg::RST_BYTE;
      evt_logic_q <= gpio_cmd_pkg::RST_BYTE;
      fn_irq_o    <= 1'b0;
    end else begin
      prev_q      <= pin_lvl_i;
      cap_q       <= cap_d;
      pend_q      <= pend_d;
      primed_q    <= 1'b1;
      evt_valid_q <= evt_valid_d;
      evt_port_q  <= evt_port_d;
      evt_logic_q <= evt_logic_d;
      fn_irq_o    <= fn_irq_d;
    end
  end
  // Event fields toward the host end
  assign lnk.evt_valid = evt_valid_q;
  assign lnk.evt_port  = evt_port_q;
  assign lnk.evt_logic = evt_logic_q;
endmodule : gpio_dev_end
`default_nettype wire

// [rtl/gpio_host_end.sv]
// Host controller: register port to GPIO commands, answers and events
`timescale 1ns/1ps
`default_nettype none
module gpio_host_end (
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  gpio_cmd_if.host         lnk,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  output logic             irq_o
);
  // Command length for each identifier
  function automatic logic [7:0] cmd_len(input logic [7:0] id);
    if (id == gpio_cmd_pkg::ID_SET_DRIVE) cmd_len = gpio_cmd_pkg::CLEN_SET_DRV;
    else if (id == gpio_cmd_pkg::ID_SET_LEVEL)
      cmd_len = gpio_cmd_pkg::CLEN_SET_LVL;
    else if (id == gpio_cmd_pkg::ID_SET_IRQ)
      cmd_len = gpio_cmd_pkg::CLEN_SET_IRQ;
    else cmd_len = gpio_cmd_pkg::CLEN_GET;
  endfunction : cmd_len

  logic        go_q, go_d, busy_q, busy_d;
  logic [7:0]  id_q, id_d, port_q, port_d;
  logic [31:0] args_q, args_d;
  logic [7:0]  argd_q, argd_d;
  logic [31:0] rsp_q, rsp_d;
  logic [15:0] info_q, info_d;
  logic [15:0] evt_q, evt_d;
  logic [gpio_cmd_pkg::ST_W-1:0] st_q, st_d, msk_q, msk_d;
  logic [31:0] rdata_d;
  logic        irq_d;

  // Register writes, command launch, answer and event capture
  always_comb begin
    go_d    = 1'b0;
    busy_d  = busy_q;
    id_d    = id_q;
    port_d  = port_q;
    args_d  = args_q;
    argd_d  = argd_q;
    rsp_d   = rsp_q;
    info_d  = info_q;
    evt_d   = evt_q;
    st_d    = st_q;
    msk_d   = msk_q;
    rdata_d = '0;
    if (wr_i) begin
      if (addr_i == gpio_cmd_pkg::REG_CTRL) begin
        if (!busy_q) begin
          go_d   = 1'b1;
          busy_d = 1'b1;
          id_d   = wdata_i[7:0];
          port_d = wdata_i[15:8];
        end
      end else if (addr_i == gpio_cmd_pkg::REG_ARGS) begin
        args_d = wdata_i;
      end else if (addr_i == gpio_cmd_pkg::REG_ARGD) begin
        argd_d = wdata_i[7:0];
      end else if (addr_i == gpio_cmd_pkg::REG_MASK) begin
        msk_d = wdata_i[gpio_cmd_pkg::ST_W-1:0];
      end
    end
    if (rd_i) begin
      if (addr_i == gpio_cmd_pkg::REG_CTRL) rdata_d = {16'h0000, port_q, id_q};
      else if (addr_i == gpio_cmd_pkg::REG_ARGS) rdata_d = args_q;
      else if (addr_i == gpio_cmd_pkg::REG_ARGD) rdata_d = {24'h000000, argd_q};
      else if (addr_i == gpio_cmd_pkg::REG_RSP_DATA) rdata_d = rsp_q;
      else if (addr_i == gpio_cmd_pkg::REG_RSP_INFO)
        rdata_d = {15'h0000, busy_q, info_q};
      else if (addr_i == gpio_cmd_pkg::REG_STATUS) begin
        rdata_d = {30'h00000000, st_q};
        st_d    = '0;
      end else if (addr_i == gpio_cmd_pkg::REG_MASK)
        rdata_d = {30'h00000000, msk_q};
      else if (addr_i == gpio_cmd_pkg::REG_EVT) rdata_d = {16'h0000, evt_q};
    end
    if (lnk.rsp_valid) begin
      busy_d = 1'b0;
      rsp_d  = {lnk.rsp_d3, lnk.rsp_d2, lnk.rsp_d1, lnk.rsp_d0};
      info_d = {lnk.rsp_len, lnk.rsp_id};
      st_d[gpio_cmd_pkg::ST_RSP] = 1'b1;           // set beats clear
    end
    if (lnk.evt_valid) begin
      evt_d = {lnk.evt_logic, lnk.evt_port};
      st_d[gpio_cmd_pkg::ST_EVT] = 1'b1;
    end
    irq_d = |(st_d & msk_d);
  end

  // Controller registers
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      go_q    <= 1'b0;
      busy_q  <= 1'b0;
      id_q    <= '0;
      port_q  <= '0;
      args_q  <= '0;
      argd_q  <= '0;
      rsp_q   <= '0;
      info_q  <= '0;
      evt_q   <= '0;
      st_q    <= '0;
      msk_q   <= '0;
      rdata_o <= '0;
      irq_o   <= 1'b0;
    end else begin
      go_q    <= go_d;
      busy_q  <= busy_d;
      id_q    <= id_d;
      port_q  <= port_d;
      args_q  <= args_d;
      argd_q  <= argd_d;
      rsp_q   <= rsp_d;
      info_q  <= info_d;
      evt_q   <= evt_d;
      st_q    <= st_d;
      msk_q   <= msk_d;
      rdata_o <= rdata_d;
      irq_o   <= irq_d;
    end
  end

  // Command fields; argument bytes stand until the next write to their register
  assign lnk.cmd_valid = go_q;
  assign lnk.cmd_type  = gpio_cmd_pkg::HDR_TYPE;
  assign lnk.cmd_group = gpio_cmd_pkg::GPIO_GROUP;
  assign lnk.cmd_len   = cmd_len(id_q);
  assign lnk.cmd_id    = id_q;
  assign lnk.cmd_port  = port_q;
  assign lnk.cmd_mask  = args_q[7:0];
  assign lnk.cmd_a     = args_q[15:8];
  assign lnk.cmd_b     = args_q[23:16];
  assign lnk.cmd_c     = args_q[31:24];
  assign lnk.cmd_d     = argd_q;
endmodule : gpio_host_end
`default_nettype wire

// [tb/gpio_cmd_checker.sv]
// Link checker for the GPIO command, answer and event wires
`timescale 1ns/1ps
`default_nettype none
module gpio_cmd_checker #(
  parameter int NUM_PORTS = 6
) (
  input wire logic       mclk_i,
  input wire logic       sys_rst_i,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_type,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] cmd_group,
  input wire logic [7:0] cmd_id,
  input wire logic [7:0] cmd_port,
  input wire logic [7:0] cmd_mask,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_id,
  input wire logic [7:0] rsp_len,
  input wire logic [7:0] rsp_d0,
  input wire logic       evt_valid,
  input wire logic [7:0] evt_port
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  // A well-formed command of one kind to an existing port
  sequence good_cmd(logic [7:0] id);
    cmd_valid && cmd_id == id && cmd_port < NUM_PORTS;
  endsequence

  rsp_follow_a: assert property (cmd_valid |=> rsp_valid)
    else $error("answer missing after command");
  rsp_cause_a: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  rsp_echo_a: assert property (cmd_valid |=> rsp_id == $past(cmd_id))
    else $error("answer id differs from command id");
  hdr_fixed_a: assert property (cmd_valid |-> cmd_type == 8'hc0
      && cmd_group == 8'h09)
    else $error("command header type or group wrong");
  lvl_len_a: assert property (cmd_valid && cmd_id == 8'h07
      |-> cmd_len == 8'h03)
    else $error("set level command length wrong");
  irq_len_a: assert property (cmd_valid && cmd_id == 8'h09
      |-> cmd_len == 8'h04)
    else $error("set edge command length wrong");
  drv_len_a: assert property (good_cmd(8'h06) |=> rsp_len == 8'h06)
    else $error("drive readback length wrong");
  getlvl_len_a: assert property (good_cmd(8'h08) |=> rsp_len == 8'h03)
    else $error("level readback length wrong");
  bad_port_a: assert property (cmd_valid && cmd_port >= NUM_PORTS
      |=> rsp_len == 8'h00 && rsp_d0 == 8'h00)
    else $error("bad port not refused");
  aff_sub_a: assert property (good_cmd(8'h07)
      |=> (rsp_d0 & ~$past(cmd_mask)) == 8'h00)
    else $error("unselected pin reported affected");
  evt_port_a: assert property (evt_valid |-> evt_port < NUM_PORTS)
    else $error("event names a missing port");
endmodule : gpio_cmd_checker
`default_nettype wire

// [tb/tb.sv]
// Testbench: host register port drives both GPIO link ends
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic            mclk_i, sys_rst_i, wr_i, rd_i, irq_o, fn_irq_o;
  logic [7:0]      addr_i;
  logic [31:0]     wdata_i, rdata_o, r, inf;
  logic [5:0][7:0] pin_lvl_i, special_fn_i, pin_out_o, pin_oe_n_o;
  logic [5:0][7:0] pull_up_o, pull_dn_o, analog_o;
  int              errors, cmp_count, fn_cnt;

  gpio_cmd_if lnk_if ();
  gpio_dev_end #(.NUM_PORTS(6)) gpio_dev_end_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .lnk(lnk_if), .pin_lvl_i(pin_lvl_i),
    .special_fn_i(special_fn_i), .pin_out_o(pin_out_o),
    .pin_oe_n_o(pin_oe_n_o), .pull_up_o(pull_up_o), .pull_dn_o(pull_dn_o),
    .analog_o(analog_o), .fn_irq_o(fn_irq_o));
  gpio_host_end gpio_host_end_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .lnk(lnk_if), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o));
  gpio_cmd_checker #(.NUM_PORTS(6)) gpio_cmd_checker_inst (.mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i), .cmd_valid(lnk_if.cmd_valid),
    .cmd_type(lnk_if.cmd_type), .cmd_len(lnk_if.cmd_len),
    .cmd_group(lnk_if.cmd_group), .cmd_id(lnk_if.cmd_id),
    .cmd_port(lnk_if.cmd_port), .cmd_mask(lnk_if.cmd_mask),
    .rsp_valid(lnk_if.rsp_valid), .rsp_id(lnk_if.rsp_id),
    .rsp_len(lnk_if.rsp_len), .rsp_d0(lnk_if.rsp_d0),
    .evt_valid(lnk_if.evt_valid), .evt_port(lnk_if.evt_port));

  // Clock at 50 ns period
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Counts special-function interrupt pulses
  always @(posedge mclk_i) begin
    if (fn_irq_o === 1'b1) fn_cnt <= fn_cnt + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // One-cycle write and read strobes, data the cycle after a read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // Launches one command and checks busy, id and answer length
  task automatic run(input logic [7:0] id, p, m, a, b, c, d, len);
    wr(8'h04, {c, b, a, m});
    wr(8'h08, {24'h0, d});
    wr(8'h00, {16'h0, p, id});
    repeat (3) @(posedge mclk_i);
    rd(8'h10, inf);
    chk("rsp_info", {15'h0, 1'b0, len, id}, inf);
    rd(8'h0c, r);
  endtask : run

  // Moves a port's levels, then checks interrupt, status and event
  task automatic pin_edge(input int p, input logic [7:0] v,
                          input logic ev, input logic iq);
    @(posedge mclk_i);
    pin_lvl_i[p] <= v;
    repeat (6) @(posedge mclk_i);
    chk("irq_o", {31'h0, iq}, {31'h0, irq_o});
    rd(8'h14, r);
    chk("evt_status", {31'h0, ev}, {31'h0, r[1]});
    if (ev) begin
      rd(8'h1c, r);
      chk("evt_reg", {16'h0, v, 8'(p)}, r & 32'hffff);
    end
    repeat (2) @(posedge mclk_i);
    chk("irq_clear", 32'h0, {31'h0, irq_o});
  endtask : pin_edge

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    repeat (5000) @(posedge mclk_i);
    errors++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    {sys_rst_i, wr_i, rd_i, addr_i, wdata_i} = {1'b1, 42'h0};
    {pin_lvl_i, special_fn_i, errors, cmp_count, fn_cnt} = '0;
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    wr(8'h18, 32'h2);
    run(8'h06, 0, 0, 0, 0, 0, 0, 8'h06);
    chk("drv_rst", 32'h0, r);
    chk("oe_rst", 32'hffffffff, pin_oe_n_o[3:0]);
    $display("test reset done");
    run(8'h05, 2, 8'h0f, 8'hff, 0, 0, 0, 8'h03);
    chk("aff_dir", 32'h0f, r & 32'hff);
    run(8'h05, 2, 8'h0f, 8'hff, 0, 0, 0, 8'h03);
    chk("aff_same", 32'h0, r & 32'hff);
    chk("oe_dir", 32'hf0, pin_oe_n_o[2]);
    run(8'h05, 3, 8'hff, 8'he0, 8'hcc, 8'haa, 8'h10, 8'h03);
    chk("aff_mode", 32'hfe, r & 32'hff);
    chk("pull_up", 32'h0a, pull_up_o[3] & 8'h1f);
    chk("pull_dn", 32'h0c, pull_dn_o[3] & 8'h1f);
    chk("analog", 32'h10, analog_o[3]);
    chk("oe_mode", 32'h3f, pin_oe_n_o[3]);
    run(8'h06, 3, 0, 0, 0, 0, 0, 8'h06);
    chk("drv3", 32'h10aacce0, r);
    run(8'h06, 2, 0, 0, 0, 0, 0, 8'h06);
    chk("drv2", 32'h0f, r);
    $display("test drive done");
    run(8'h07, 3, 8'hff, 8'ha0, 0, 0, 0, 8'h03);
    chk("aff_lvl", 32'ha0, r & 32'hff);
    chk("oe_lvl", 32'h1f, pin_oe_n_o[3]);
    chk("out_lvl", 32'ha0, pin_out_o[3] & 8'he0);
    run(8'h07, 3, 8'h80, 8'h00, 0, 0, 0, 8'h03);
    chk("aff_part", 32'h80, r & 32'hff);
    run(8'h08, 3, 0, 0, 0, 0, 0, 8'h03);
    chk("get_lvl", 32'h20, r & 32'hff);
    wr(8'h00, 32'h0308);
    wr(8'h00, 32'h0006); // Refused: first answer not yet taken
    repeat (3) @(posedge mclk_i);
    rd(8'h10, inf);
    chk("busy_refuse", 32'h0308, inf);
    rd(8'h0c, r);
    chk("get_lvl_again", 32'h20, r & 32'hff);
    run(8'h08, 6, 0, 0, 0, 0, 0, 8'h00);
    chk("bad_port", 32'h0, r);
    rd(8'h40, r);
    chk("unmapped", 32'h0, r);
    $display("test level done");
    run(8'h09, 1, 8'h03, 8'h01, 8'h02, 0, 0, 8'h03);
    chk("aff_irq", 32'h03, r & 32'hff);
    run(8'h0a, 1, 0, 0, 0, 0, 0, 8'h04);
    chk("get_irq", 32'h0201, r & 32'hffff);
    rd(8'h14, r);
    pin_edge(1, 8'h01, 1'b1, 1'b1);
    pin_edge(1, 8'h00, 1'b0, 1'b0);
    pin_edge(1, 8'h02, 1'b0, 1'b0);
    pin_edge(1, 8'h00, 1'b1, 1'b1);
    pin_edge(1, 8'h04, 1'b0, 1'b0);
    wr(8'h18, 32'h0);
    pin_edge(1, 8'h05, 1'b1, 1'b0);
    $display("test edge done");
    @(posedge mclk_i);
    special_fn_i[4] <= 8'h01;
    repeat (3) @(posedge mclk_i);
    fn_cnt <= 0;
    wr(8'h18, 32'h3);
    pin_edge(4, 8'h01, 1'b0, 1'b0);
    chk("fn_irq", 32'h1, fn_cnt);
    run(8'h06, 0, 0, 0, 0, 0, 0, 8'h06);
    repeat (2) @(posedge mclk_i);
    chk("irq_rsp", 32'h1, {31'h0, irq_o});
    rd(8'h14, r);
    chk("rsp_status", 32'h1, r & 32'h3);
    $display("test interrupt done");
    report_and_stop;
  end
endmodule : tb
`default_nettype wire
